// *** logic/cpcc_pkg.sv ***
// Package for the counter and PWM cycle configuration block.
// Assumes one system clock and byte-wide special-function register access.
`default_nettype none
package cpcc_pkg;
  // Register addresses in the special-function register space
  localparam logic [7:0] OFS_CPM0 = 8'hda;
  localparam logic [7:0] OFS_PWM  = 8'hdf;
  localparam logic [7:0] OFS_CNTL = 8'hf9;
  localparam logic [7:0] OFS_CNTH = 8'hfa;
  localparam logic [7:0] OFS_CPL0 = 8'hfb;
  localparam logic [7:0] OFS_CPH0 = 8'hfc;
  // Field positions of the PWM cycle configuration register
  localparam int BIT_RELOAD_SEL = 7;
  localparam int BIT_WRAP_IE    = 6;
  localparam int BIT_WRAP_FLAG  = 5;
  localparam int BIT_CYC_WIDTH  = 0;
  // Field positions of the channel mode control register
  localparam int BIT_WIDE  = 7;
  localparam int BIT_ECOM  = 6;
  localparam int BIT_PWM   = 1;
  // Reset values, counter maximum and counter increment
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_MAX  = 16'hffff;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  // Cycle length masks for 8, 9, 10 and 11 bit cycles
  localparam logic [15:0] MASK_8  = 16'h00ff;
  localparam logic [15:0] MASK_9  = 16'h01ff;
  localparam logic [15:0] MASK_10 = 16'h03ff;
  localparam logic [15:0] MASK_11 = 16'h07ff;

  typedef enum logic [1:0] {
    CPCC_LEN_8  = 2'h0,
    CPCC_LEN_9  = 2'h1,
    CPCC_LEN_10 = 2'h2,
    CPCC_LEN_11 = 2'h3
  } cpcc_len_t;

  // One register bus request, held for one cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cpcc_sfr_req_t;
endpackage
`default_nettype wire

// *** logic/cpcc_chan.sv ***
// Channel 0 compare, auto-reload bank and PWM output.
// Assumes register strobes and counter state arrive on the same clock.
`default_nettype none
module cpcc_chan
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        wr_cpm_i,
  input  wire logic        wr_cpl_i,
  input  wire logic        wr_cph_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        reload_sel_i,
  input  wire logic [15:0] cnt_i,
  input  wire logic [15:0] cyc_mask_i,
  input  wire logic        cyc_wrap_i,
  output var  logic [7:0]  cpm_o,
  output var  logic [7:0]  cpl_view_o,
  output var  logic [7:0]  cph_view_o,
  output var  logic        pwm_o
);
  logic [7:0]  mode_reg;
  logic [7:0]  cpl_reg;
  logic [7:0]  cph_reg;
  logic [7:0]  arl_reg;
  logic [7:0]  arh_reg;
  logic        pwm_reg;
  logic        pwm_next;
  logic        wide;
  logic        narrow;
  logic        ecom;
  logic        any_wr;
  logic [15:0] cmp_word;

  // Mode decode; the cycle width reaches only narrow PWM channels
  assign wide     = mode_reg[cpcc_pkg::BIT_WIDE];
  assign ecom     = mode_reg[cpcc_pkg::BIT_ECOM];
  assign narrow   = mode_reg[cpcc_pkg::BIT_PWM] & ~wide;  // RULE7
  assign any_wr   = wr_cpl_i | wr_cph_i | wr_cpm_i;
  assign cmp_word = {cph_reg, cpl_reg};

  // Same addresses reach either bank, picked by the reload select
  assign cpl_view_o = reload_sel_i ? arl_reg : cpl_reg;  // RULE1
  assign cph_view_o = reload_sel_i ? arh_reg : cph_reg;  // RULE1
  assign cpm_o      = mode_reg;
  assign pwm_o      = pwm_reg;

  // Output high while the counter sits below the compare value
  assign pwm_next = ecom & mode_reg[cpcc_pkg::BIT_PWM] &
    (wide ? (cnt_i < cmp_word) : ((cnt_i & cyc_mask_i) < (cmp_word & cyc_mask_i)));  // RULE7

  // Register writes, reload at cycle wrap; writes win over the reload
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_reg <= cpcc_pkg::RST_BYTE;
      cpl_reg  <= cpcc_pkg::RST_BYTE;
      cph_reg  <= cpcc_pkg::RST_BYTE;
      arl_reg  <= cpcc_pkg::RST_BYTE;
      arh_reg  <= cpcc_pkg::RST_BYTE;
      pwm_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      pwm_reg <= pwm_next;
      if (wr_cpm_i)
        mode_reg <= wdata_i;
      if (wr_cpl_i && reload_sel_i)
        arl_reg <= wdata_i;  // RULE1
      if (wr_cph_i && reload_sel_i)
        arh_reg <= wdata_i;  // RULE1
      if (wr_cpl_i && !reload_sel_i)
      begin
        cpl_reg                     <= wdata_i;
        mode_reg[cpcc_pkg::BIT_ECOM] <= 1'b0;  // Low write disarms the comparator
      end
      if (wr_cph_i && !reload_sel_i)
      begin
        cph_reg                     <= wdata_i;
        mode_reg[cpcc_pkg::BIT_ECOM] <= 1'b1;  // High write rearms it
      end
      if (cyc_wrap_i && narrow && !any_wr)
      begin
        cpl_reg <= arl_reg;  // RULE15
        cph_reg <= arh_reg;  // RULE2
      end
    end
  end

  chk_reload_xfer : assert property (@(posedge clk_i) disable iff (!nrst_i)  // RULE15
    ce_i && cyc_wrap_i && narrow && !any_wr |=> {cph_reg, cpl_reg} == $past({arh_reg, arl_reg}))
    else $error("Reload value not moved into compare at cycle wrap");
  chk_reload_idle : assert property (@(posedge clk_i) disable iff (!nrst_i)  // RULE2
    !narrow && !any_wr |=> $stable({cph_reg, cpl_reg}))
    else $error("Reload bank changed compare outside narrow PWM");
  chk_bank_select : assert property (@(posedge clk_i) disable iff (!nrst_i)  // RULE1
    ce_i && wr_cpl_i && reload_sel_i |=> arl_reg == $past(wdata_i) && $stable(cpl_reg))
    else $error("Reload select did not steer the low byte write");
endmodule // cpcc_chan
`default_nettype wire

// *** logic/cpcc_top.sv ***
// Counter byte access, PWM cycle configuration and cycle wrap flag.
// Assumes the count tick, watchdog enable and flag clear come from logic on CLK_I.
//
// What this block does
// RULE1: Reload bank select steers compare byte addresses to the compare or reload bank.
// RULE2: Auto-reload contents only matter for channels in 8 to 11-bit PWM.
// RULE3: The cycle wrap flag raises the interrupt only while its enable bit is set.
// RULE4: The cycle wrap flag is set on overflow out of the selected 8th to 11th counter bit.
// RULE5: Hardware or firmware may set the cycle wrap flag, and only firmware clears it.
// RULE6: Cycle width codes 00, 01, 10 and 11 select 8, 9, 10 and 11-bit cycles.
// RULE7: The cycle width applies to PWM channels not in 16-bit mode and is ignored by 16-bit ones.
// RULE8: Software writes zero into reserved bits 4:2, which read as zero.
// RULE9: The counter low byte is a readable and writable register.
// RULE10: Reading the high byte returns a snapshot loaded when the low byte is read.
// RULE11: High byte writes are ignored while the watchdog is enabled.
// RULE12: Low byte writes are ignored while the watchdog is enabled.
// RULE13: The watchdog enable bit dedicates channel 2 to the watchdog.
// RULE14: Counter wrap from all ones to zero sets the overflow flag; only firmware clears it.
// RULE15: Narrow PWM channels load the auto-reload value into compare at each cycle wrap that has no channel register write in the same cycle.
`default_nettype none
module cpcc_top
(
  input  wire logic                    CLK_I,
  input  wire logic                    NRST_I,
  input  wire logic                    CE_I,
  input  wire cpcc_pkg::cpcc_sfr_req_t SFR_REQ_I,
  input  wire logic                    COUNT_TICK_I,
  input  wire logic                    WDOG_EN_I,
  input  wire logic                    CNT_OVF_CLR_I,
  output var  logic [7:0]              SFR_RDATA_O,
  output var  logic                    CYC_IRQ_O,
  output var  logic                    CNT_OVF_FLAG_O,
  output var  logic                    PWM0_O,
  output var  logic                    WDOG_CH2_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  logic        reload_sel_reg;
  logic        wrap_ie_reg;
  logic        wrap_flag_reg;
  logic        wrap_flag_next;
  logic [1:0]  cyc_width_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [7:0]  snap_reg;
  logic        ovf_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rd_mux;
  logic        irq_reg;
  logic        wdog_reg;
  logic        wr_pwm;
  logic        wr_cntl;
  logic        wr_cnth;
  logic        rd_cntl;
  logic        wr_cpm;
  logic        wr_cpl;
  logic        wr_cph;
  logic        tick;
  logic        cyc_wrap;
  logic        cnt_wrap;
  logic [15:0] cyc_mask;
  logic [7:0]  pwm_cfg;
  logic [7:0]  chan_cpm;
  logic [7:0]  chan_cpl;
  logic [7:0]  chan_cph;
  logic        chan_pwm;

  // Address decode of single-cycle strobes
  assign wr_pwm  = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_PWM);
  assign wr_cntl = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_CNTL);
  assign wr_cnth = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_CNTH);
  assign rd_cntl = SFR_REQ_I.rd && (SFR_REQ_I.addr == cpcc_pkg::OFS_CNTL);
  assign wr_cpm  = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_CPM0);
  assign wr_cpl  = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_CPL0);
  assign wr_cph  = SFR_REQ_I.wr && (SFR_REQ_I.addr == cpcc_pkg::OFS_CPH0);

  // Cycle length mask from the width field
  assign cyc_mask = (cyc_width_reg == cpcc_pkg::CPCC_LEN_8)  ? cpcc_pkg::MASK_8  :  // RULE6
                    (cyc_width_reg == cpcc_pkg::CPCC_LEN_9)  ? cpcc_pkg::MASK_9  :
                    (cyc_width_reg == cpcc_pkg::CPCC_LEN_10) ? cpcc_pkg::MASK_10 :
                    cpcc_pkg::MASK_11;

  // Overflow out of the selected bit, and out of the full counter
  assign tick     = COUNT_TICK_I;
  assign cyc_wrap = tick && ((cnt_reg & cyc_mask) == cyc_mask);  // RULE4
  assign cnt_wrap = tick && (cnt_reg == cpcc_pkg::CNT_MAX);  // RULE14

  // Firmware writes are locked out while the watchdog runs; a write beats the tick
  assign cnt_next = (wr_cntl && !WDOG_EN_I) ? {cnt_reg[15:8], SFR_REQ_I.wdata} :  // RULE12
                    (wr_cnth && !WDOG_EN_I) ? {SFR_REQ_I.wdata, cnt_reg[7:0]} :  // RULE11
                    tick ? (cnt_reg + cpcc_pkg::CNT_ONE) : cnt_reg;  // RULE9

  // A hardware set wins over a firmware clear in the same cycle
  assign wrap_flag_next = cyc_wrap ? 1'b1 :  // RULE5
                          wr_pwm ? SFR_REQ_I.wdata[cpcc_pkg::BIT_WRAP_FLAG] : wrap_flag_reg;

  // Reserved bits 4:2 always read back as zero
  assign pwm_cfg = {reload_sel_reg, wrap_ie_reg, wrap_flag_reg, 3'h0, cyc_width_reg};  // RULE8

  // Read data; unmapped addresses answer zero
  assign rd_mux = (SFR_REQ_I.addr == cpcc_pkg::OFS_PWM)  ? pwm_cfg  :
                  (SFR_REQ_I.addr == cpcc_pkg::OFS_CNTL) ? cnt_reg[7:0] :  // RULE9
                  (SFR_REQ_I.addr == cpcc_pkg::OFS_CNTH) ? snap_reg :  // RULE10
                  (SFR_REQ_I.addr == cpcc_pkg::OFS_CPM0) ? chan_cpm :
                  (SFR_REQ_I.addr == cpcc_pkg::OFS_CPL0) ? chan_cpl :
                  (SFR_REQ_I.addr == cpcc_pkg::OFS_CPH0) ? chan_cph : cpcc_pkg::RST_BYTE;

  // Configuration, counter and flags
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      reload_sel_reg <= 1'b0;
      wrap_ie_reg    <= 1'b0;
      wrap_flag_reg  <= 1'b0;
      cyc_width_reg  <= cpcc_pkg::CPCC_LEN_8;
      cnt_reg        <= cpcc_pkg::RST_WORD;
      ovf_reg        <= 1'b0;
    end
    else if (CE_I)
    begin
      if (wr_pwm)
      begin
        reload_sel_reg <= SFR_REQ_I.wdata[cpcc_pkg::BIT_RELOAD_SEL];
        wrap_ie_reg    <= SFR_REQ_I.wdata[cpcc_pkg::BIT_WRAP_IE];
        cyc_width_reg  <= SFR_REQ_I.wdata[cpcc_pkg::BIT_CYC_WIDTH +: 2];  // RULE6
      end
      wrap_flag_reg <= wrap_flag_next;  // RULE5
      cnt_reg       <= cnt_next;
      ovf_reg       <= cnt_wrap | (ovf_reg & ~CNT_OVF_CLR_I);  // RULE14
    end
  end

  // Snapshot, read data and registered outputs
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      snap_reg  <= cpcc_pkg::RST_BYTE;
      rdata_reg <= cpcc_pkg::RST_BYTE;
      irq_reg   <= 1'b0;
      wdog_reg  <= 1'b0;
    end
    else if (CE_I)
    begin
      if (rd_cntl)
        snap_reg <= cnt_reg[15:8];  // RULE10
      if (SFR_REQ_I.rd)
        rdata_reg <= rd_mux;
      irq_reg  <= wrap_flag_reg & wrap_ie_reg;  // RULE3
      wdog_reg <= WDOG_EN_I;  // RULE13
    end
  end

  assign SFR_RDATA_O    = rdata_reg;
  assign CYC_IRQ_O      = irq_reg;
  assign CNT_OVF_FLAG_O = ovf_reg;
  assign WDOG_CH2_O     = wdog_reg;
  assign PWM0_O         = chan_pwm;

  // Channel 0 sits behind the shared cycle configuration
  cpcc_chan u_chan0
  (
    .clk_i        (CLK_I),
    .nrst_i       (NRST_I),
    .ce_i         (CE_I),
    .wr_cpm_i     (wr_cpm),
    .wr_cpl_i     (wr_cpl),
    .wr_cph_i     (wr_cph),
    .wdata_i      (SFR_REQ_I.wdata),
    .reload_sel_i (reload_sel_reg),
    .cnt_i        (cnt_reg),
    .cyc_mask_i   (cyc_mask),
    .cyc_wrap_i   (cyc_wrap),
    .cpm_o        (chan_cpm),
    .cpl_view_o   (chan_cpl),
    .cph_view_o   (chan_cph),
    .pwm_o        (chan_pwm)
  );

  chk_irq_gate : assert property (CE_I && wrap_flag_reg && wrap_ie_reg |=> CYC_IRQ_O)  // RULE3
    else $error("Enabled cycle wrap flag did not raise interrupt");
  chk_irq_mask : assert property (CE_I && !wrap_ie_reg |=> !CYC_IRQ_O)  // RULE3
    else $error("Masked cycle wrap flag raised interrupt");
  chk_cyc_set : assert property (CE_I && cyc_wrap |=> wrap_flag_reg)  // RULE4
    else $error("Cycle wrap flag missed an overflow");
  chk_cyc_hold : assert property (  // RULE5
    wrap_flag_reg && !(wr_pwm && !SFR_REQ_I.wdata[cpcc_pkg::BIT_WRAP_FLAG]) |=> wrap_flag_reg)
    else $error("Cycle wrap flag cleared by hardware");
  chk_width_nine : assert property (  // RULE6
    CE_I && cyc_width_reg == 2'h1 && tick && cnt_reg[8:0] == 9'h1ff |=> wrap_flag_reg)
    else $error("Nine bit cycle overflow not flagged");
  chk_width_ten : assert property (  // RULE6
    cyc_width_reg == 2'h2 && wrap_flag_reg == 1'b0 && !wr_pwm &&
    cnt_reg[9:0] != 10'h3ff |=> !wrap_flag_reg)
    else $error("Ten bit cycle flagged early");
  chk_lo_lock : assert property (  // RULE12
    WDOG_EN_I && wr_cntl && !tick |=> cnt_reg == $past(cnt_reg))
    else $error("Counter low byte written while watchdog enabled");
  chk_hi_lock : assert property (  // RULE11
    WDOG_EN_I && wr_cnth && !tick |=> cnt_reg == $past(cnt_reg))
    else $error("Counter high byte written while watchdog enabled");
  chk_snap_load : assert property (  // RULE10
    CE_I && rd_cntl |=> snap_reg == $past(cnt_reg[15:8]))
    else $error("Snapshot not loaded on low byte read");
  chk_snap_hold : assert property (!rd_cntl |=> $stable(snap_reg))  // RULE10
    else $error("Snapshot changed without a low byte read");
  chk_cf_wrap : assert property (  // RULE14
    CE_I && cnt_wrap && !(wr_cntl || wr_cnth) |=> CNT_OVF_FLAG_O && cnt_reg == 16'h0000)
    else $error("Counter wrap did not set overflow flag");
  chk_rsvd_zero : assert property (  // RULE8
    SFR_REQ_I.rd && SFR_REQ_I.addr == cpcc_pkg::OFS_PWM && CE_I |=> SFR_RDATA_O[4:2] == 3'h0)
    else $error("Reserved configuration bits read nonzero");
  chk_wdog_ch2 : assert property (CE_I && WDOG_EN_I |=> WDOG_CH2_O)  // RULE13
    else $error("Channel 2 not handed to watchdog");
endmodule // cpcc_top
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the counter byte access and PWM cycle configuration block.
// Assumes the block alone on a 10 MHz clock, inputs driven on the falling edge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk;
  logic                    nrst_n;
  cpcc_pkg::cpcc_sfr_req_t req;
  logic                    tick_in;
  logic                    wdog;
  logic                    ovf_clr;
  logic [7:0]              rdata;
  logic                    irq;
  logic                    ovf_flag;
  logic                    pwm0;
  logic                    wdog_ch2;
  logic                    ce;
  logic [7:0]              v;
  logic [15:0]             mask;
  int                      num_errors;
  int                      checks_done;
  int                      cycles = 0;

  cpcc_top DUT (
    .CLK_I(clk), .NRST_I(nrst_n), .CE_I(ce), .SFR_REQ_I(req), .COUNT_TICK_I(tick_in),
    .WDOG_EN_I(wdog), .CNT_OVF_CLR_I(ovf_clr), .SFR_RDATA_O(rdata), .CYC_IRQ_O(irq),
    .CNT_OVF_FLAG_O(ovf_flag), .PWM0_O(pwm0), .WDOG_CH2_O(wdog_ch2)
  );

  // Free-running system clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  // One-cycle bus pulses; each leaves a free edge before the next request
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    req.rd = 1'b0;
    d = rdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    sfr_rd(a, v);
    chk8(what, exp, v);
  endtask

  task automatic set_cnt(input logic [15:0] c);
    sfr_wr(8'hf9, c[7:0]);
    sfr_wr(8'hfa, c[15:8]);
  endtask

  task automatic tick_once();
    @(negedge clk);
    tick_in = 1'b1;
    @(negedge clk);
    tick_in = 1'b0;
  endtask

  task automatic test_reset();
    rd_chk("mode reset", 8'hda, 8'h00);
    rd_chk("config reset", 8'hdf, 8'h00);
    rd_chk("count low reset", 8'hf9, 8'h00);
    rd_chk("count high reset", 8'hfa, 8'h00);
    rd_chk("unmapped read", 8'h55, 8'h00);
  endtask

  // Reserved bits are written as zero and read back as zero; flag set by firmware
  task automatic test_config();
    sfr_wr(8'hdf, 8'he3);
    rd_chk("config readback", 8'hdf, 8'he3);
    chk1("irq enabled", 1'b1, irq);
    sfr_wr(8'hdf, 8'ha3);
    @(negedge clk);
    chk1("irq masked", 1'b0, irq);
    rd_chk("flag held", 8'hdf, 8'ha3);
    sfr_wr(8'hdf, 8'h00);
    rd_chk("flag cleared", 8'hdf, 8'h00);
  endtask

  // Every width code: no flag at the next narrower boundary, flag at its own
  task automatic test_wrap();
    for (int k = 0; k < 4; k++)
    begin
      mask = (16'h0100 << k) - 16'h0001;
      sfr_wr(8'hdf, 8'(k));
      set_cnt(mask >> 1);
      tick_once();
      rd_chk("no early wrap", 8'hdf, 8'(k));
      set_cnt(mask);
      tick_once();
      tick_once();
      rd_chk("wrap flag", 8'hdf, 8'(k) | 8'h20);
      chk1("irq off", 1'b0, irq);
    end
    sfr_wr(8'hdf, 8'h43);
    @(negedge clk);
    chk1("irq with flag clear", 1'b0, irq);
    set_cnt(16'h07ff);
    tick_once();
    chk1("irq one edge late", 1'b0, irq);
    @(negedge clk);
    chk1("irq on wrap", 1'b1, irq);
    sfr_wr(8'hdf, 8'h00);
  endtask

  task automatic test_snapshot();
    set_cnt(16'h12ff);
    rd_chk("low byte", 8'hf9, 8'hff);
    tick_once();
    rd_chk("snapshot high", 8'hfa, 8'h12);
    rd_chk("low after tick", 8'hf9, 8'h00);
    rd_chk("fresh high", 8'hfa, 8'h13);
  endtask

  task automatic test_watchdog();
    set_cnt(16'h3456);
    @(negedge clk);
    wdog = 1'b1;
    @(negedge clk);
    chk1("channel 2 owned", 1'b1, wdog_ch2);
    set_cnt(16'habcd);
    rd_chk("low locked", 8'hf9, 8'h56);
    rd_chk("high locked", 8'hfa, 8'h34);
    wdog = 1'b0;
    set_cnt(16'habcd);
    rd_chk("low open", 8'hf9, 8'hcd);
    rd_chk("high open", 8'hfa, 8'hab);
    chk1("channel 2 freed", 1'b0, wdog_ch2);
  endtask

  task automatic test_overflow();
    set_cnt(16'hfffe);
    tick_once();
    chk1("no early overflow", 1'b0, ovf_flag);
    tick_once();
    chk1("overflow set", 1'b1, ovf_flag);
    tick_once();
    chk1("overflow kept", 1'b1, ovf_flag);
    @(negedge clk);
    ovf_clr = 1'b1;
    @(negedge clk);
    ovf_clr = 1'b0;
    chk1("overflow cleared", 1'b0, ovf_flag);
  endtask

  // Two banks behind one address pair; a wrap outside PWM leaves compare alone
  task automatic test_bank();
    sfr_wr(8'hfb, 8'h11);
    sfr_wr(8'hfc, 8'h22);
    sfr_wr(8'hdf, 8'h80);
    sfr_wr(8'hfb, 8'h33);
    sfr_wr(8'hfc, 8'h44);
    rd_chk("reload low", 8'hfb, 8'h33);
    rd_chk("reload high", 8'hfc, 8'h44);
    sfr_wr(8'hdf, 8'h00);
    set_cnt(16'h00ff);
    tick_once();
    rd_chk("compare low", 8'hfb, 8'h11);
    rd_chk("compare high", 8'hfc, 8'h22);
  endtask

  // Compare 0x0180 against count 0x0090 tells 8-bit cycles apart from 9-bit and 16-bit ones
  task automatic test_pwm();
    sfr_wr(8'hda, 8'h42);
    sfr_wr(8'hfb, 8'h80);
    sfr_wr(8'hfc, 8'h01);
    set_cnt(16'h0090);
    @(negedge clk);
    chk1("pwm 8 bit", 1'b0, pwm0);
    sfr_wr(8'hdf, 8'h01);
    @(negedge clk);
    chk1("pwm 9 bit", 1'b1, pwm0);
    sfr_wr(8'hdf, 8'h00);
    sfr_wr(8'hda, 8'hc2);
    @(negedge clk);
    chk1("pwm 16 bit", 1'b1, pwm0);
    sfr_wr(8'hda, 8'h42);
    sfr_wr(8'hdf, 8'h80);
    sfr_wr(8'hfb, 8'h55);
    sfr_wr(8'hfc, 8'h00);
    set_cnt(16'h00ff);
    tick_once();
    sfr_wr(8'hdf, 8'h00);
    rd_chk("reloaded low", 8'hfb, 8'h55);
    rd_chk("reloaded high", 8'hfc, 8'h00);
  endtask

  // Clock enable low freezes the counter and drops bus writes
  task automatic test_freeze();
    set_cnt(16'h0010);
    @(negedge clk);
    ce = 1'b0;
    tick_once();
    sfr_wr(8'hf9, 8'h77);
    @(negedge clk);
    ce = 1'b1;
    rd_chk("frozen low", 8'hf9, 8'h10);
  endtask

  // Main sequence
  initial
  begin
    req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    tick_in = 1'b0;
    wdog = 1'b0;
    ovf_clr = 1'b0;
    ce = 1'b1;
    num_errors = 0;
    checks_done = 0;
    nrst_n = 1'b0;
    repeat (20) @(negedge clk);
    nrst_n = 1'b1;
    test_reset();
    test_config();
    test_wrap();
    test_snapshot();
    test_watchdog();
    test_overflow();
    test_bank();
    test_pwm();
    test_freeze();
    test_done();
  end
endmodule // tb_top
`default_nettype wire
